// *** design/ddct_defs.svh ***
/*
 * Constants of the dual down-counter timer: widths and reset values.
 * Assumes inclusion by its bare name from files under design/.
 */
`ifndef DDCT_DEFS_SVH
`define DDCT_DEFS_SVH

// Width of one channel counter and of one nibble.
`define DDCT_CNT_W        8
`define DDCT_NIB_W        4
// Reset value of counters and reload registers.
`define DDCT_CNT_RST      8'h00
`define DDCT_RELOAD_RST   8'hff
// Reset value of the run controls and the oscillator switch.
`define DDCT_RUN_RST      1'b0
`define DDCT_OSC_RST      1'b0
// Reset value of the port data bits and float controls.
`define DDCT_PORT_DATA_RST  1'b1
`define DDCT_PORT_FLOAT_RST 1'b1

`endif

// *** design/ddct_pkg.sv ***
/*
 * Types shared by the dual down-counter timer.
 * Assumes ddct_defs.svh is available on the include path.
 */
package ddct_pkg;

   // Input clock source of one channel.
   typedef enum logic [1:0] {
      DDCT_SRC_INTERNAL,
      DDCT_SRC_FAST_OSC,
      DDCT_SRC_EVENT
   } ddct_src_t;

   // Configuration of one channel as software sets it.
   typedef struct packed {
      ddct_src_t  src;         // Clock source select.
      logic [7:0] reload;      // Value loaded on underflow.
   } ddct_chan_cfg_t;

   // Configuration of one special output port bit.
   typedef struct packed {
      logic special_sel;       // Pin carries the timer output when set and data is one.
      logic data;              // Port data register bit.
      logic float_ctl;         // High-impedance control.
   } ddct_port_cfg_t;

   // Sampled clock levels presented to a channel.
   typedef struct packed {
      logic internal_clk;      // Internal prescaled clock level.
      logic fast_osc_clk;      // Fast oscillator clock level.
   } ddct_clk_in_t;

endpackage

// *** design/ddct_timer.sv ***
/*
 * Dual 8-bit down-counter timer, chainable into one 16-bit counter, with run
 * control synchronised to the input clock, nibble reads with high-half latch,
 * a gated timer output and two special output port bits.
 * Assumes all inputs are synchronous to clk_i; clock sources arrive as levels
 * and a falling level is the counting edge.
 */
`include "ddct_defs.svh"

module ddct_timer (
   input  wire logic                    clk_i,            // System clock, 200 MHz.
   input  wire logic                    rst_i,            // Synchronous reset, active high.
   input  wire ddct_pkg::ddct_clk_in_t  clk_src_i,        // Internal and fast oscillator clock levels.
   input  wire logic                    event_clock_pin_i,// Event clock pin level.
   input  wire ddct_pkg::ddct_chan_cfg_t chan0_cfg_i,     // Channel 0 configuration.
   input  wire ddct_pkg::ddct_chan_cfg_t chan1_cfg_i,     // Channel 1 configuration.
   input  wire logic                    chain_16_i,       // Chain both channels into 16 bits.
   input  wire logic                    chan0_run_ctl_i,  // Channel 0 run control write data.
   input  wire logic                    chan0_run_wr_i,   // Channel 0 run control write strobe.
   input  wire logic                    chan1_run_ctl_i,  // Channel 1 run control write data.
   input  wire logic                    chan1_run_wr_i,   // Channel 1 run control write strobe.
   input  wire logic                    fast_osc_on_i,    // Fast oscillator switch write data.
   input  wire logic                    fast_osc_wr_i,    // Fast oscillator switch write strobe.
   input  wire logic [1:0]              rd_low_i,         // Low nibble read strobe per channel.
   input  wire logic                    timer_out_enable_i, // Timer output enable register.
   input  wire ddct_pkg::ddct_port_cfg_t port_a_cfg_i,    // Special port bit A controls.
   input  wire ddct_pkg::ddct_port_cfg_t port_b_cfg_i,    // Special port bit B controls.
   output logic                         chan0_run_ctl_o,  // Channel 0 run readback.
   output logic                         chan1_run_ctl_o,  // Channel 1 run readback.
   output logic [3:0]                   chan0_count_low_nibble_o,  // Channel 0 low nibble.
   output logic [3:0]                   chan0_count_high_nibble_o, // Channel 0 latched high nibble.
   output logic [3:0]                   chan1_count_low_nibble_o,  // Channel 1 low nibble.
   output logic [3:0]                   chan1_count_high_nibble_o, // Channel 1 latched high nibble.
   output logic                         fast_oscillator_on_o, // Fast oscillator enable.
   output logic                         event_port_in_o,  // Event pin level to input port.
   output logic                         timer_out_signal_o, // Gated timer output.
   output logic                         special_port_bit_a_o,  // Port A pin level.
   output logic                         special_port_bit_a_oe_n_o, // Port A drive, low drives.
   output logic                         special_port_bit_b_o,  // Port B pin level.
   output logic                         special_port_bit_b_oe_n_o  // Port B drive, low drives.
);

   // Counters, reload flags and run state of both channels.
   logic [7:0] cnt_r     [2];       // Live counter values.
   logic [7:0] cnt_nxt   [2];       // Next counter values.
   logic [1:0] run_req_r;           // Run control as last written.
   logic [1:0] run_act_r;           // Run state actually in force.
   logic [1:0] run_act_nxt;         // Next run state.
   logic [2:0] lvl_r;               // Previous internal, fast and event levels.
   logic [1:0] fall;                // Falling edge of each channel's input clock.
   logic [1:0] uflow;               // Underflow of each channel this cycle.
   logic       timer_out_signal_r;              // Raw timer output toggled on underflow.
   logic [3:0] hi_latch_r [2];      // High nibble captured on low read.
   logic       osc_r;               // Fast oscillator switch.

   // Selects the falling edge of a channel's chosen source; a stopped
   // fast oscillator yields no edges so the channel cannot advance.
   function automatic logic src_fall(input ddct_pkg::ddct_src_t s, input logic [2:0] now,
                                     input logic [2:0] prev, input logic osc);
      case (s)
         ddct_pkg::DDCT_SRC_INTERNAL: src_fall = prev[0] & ~now[0];
         ddct_pkg::DDCT_SRC_FAST_OSC: src_fall = osc & prev[1] & ~now[1];
         ddct_pkg::DDCT_SRC_EVENT:    src_fall = prev[2] & ~now[2];
         default:                     src_fall = 1'b0;
      endcase
   endfunction

   wire logic [2:0] lvl_now = {event_clock_pin_i, clk_src_i.fast_osc_clk, clk_src_i.internal_clk};

   assign fall[0] = src_fall(chan0_cfg_i.src, lvl_now, lvl_r, osc_r);
   // In chained mode channel 1 counts on channel 0 underflow instead of its own clock.
   assign fall[1] = chain_16_i ? fall[0] : src_fall(chan1_cfg_i.src, lvl_now, lvl_r, osc_r);

   // Channel 0 underflows at zero; channel 1 in chained mode only when both are zero.
   assign uflow[0] = fall[0] & run_act_r[0] & (cnt_r[0] == `DDCT_CNT_RST);
   assign uflow[1] = chain_16_i ? (uflow[0] & (cnt_r[1] == `DDCT_CNT_RST))
                                : (fall[1] & run_act_r[1] & (cnt_r[1] == `DDCT_CNT_RST));

   // Counting: a running channel decrements on every input falling edge, except channel 1 in chained mode, which steps on channel 0's borrow.
   // The stop taking effect on that same edge still decrements once.
   always_comb begin
      cnt_nxt[0] = cnt_r[0];
      if (fall[0] && run_act_r[0]) begin
         cnt_nxt[0] = uflow[0] ? chan0_cfg_i.reload : cnt_r[0] - 8'h01;
      end
      cnt_nxt[1] = cnt_r[1];
      if (chain_16_i) begin
         // Borrow from the low byte steps the high byte.
         if (fall[0] && run_act_r[0] && cnt_r[0] == `DDCT_CNT_RST) begin
            cnt_nxt[1] = uflow[1] ? chan1_cfg_i.reload : cnt_r[1] - 8'h01;
         end
      end else if (fall[1] && run_act_r[1]) begin
         cnt_nxt[1] = uflow[1] ? chan1_cfg_i.reload : cnt_r[1] - 8'h01;
      end
   end

   // The requested run state is adopted only at an input falling edge, so a
   // write with no clock activity leaves the channel where it was.
   always_comb begin
      run_act_nxt = run_act_r;
      if (fall[0]) begin
         run_act_nxt[0] = run_req_r[0];
      end
      if (fall[1]) begin
         run_act_nxt[1] = chain_16_i ? run_req_r[0] : run_req_r[1];
      end
   end

   // Run control registers take software writes immediately.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_req_r <= {2{`DDCT_RUN_RST}};
      end else begin
         if (chan0_run_wr_i) run_req_r[0] <= chan0_run_ctl_i;
         if (chan1_run_wr_i) run_req_r[1] <= chan1_run_ctl_i;
      end
   end

   // Counter and run state registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r[0]  <= `DDCT_CNT_RST;
         cnt_r[1]  <= `DDCT_CNT_RST;
         run_act_r <= {2{`DDCT_RUN_RST}};
         lvl_r     <= 3'h0;
      end else begin
         cnt_r[0]  <= cnt_nxt[0];
         cnt_r[1]  <= cnt_nxt[1];
         run_act_r <= run_act_nxt;
         lvl_r     <= lvl_now;
      end
   end

   // Readback shows one while either the request or the real state is set,
   // so a cleared run still reads one until the channel has halted.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan0_run_ctl_o <= `DDCT_RUN_RST;
         chan1_run_ctl_o <= `DDCT_RUN_RST;
      end else begin
         chan0_run_ctl_o <= run_req_r[0] | run_act_nxt[0];
         chan1_run_ctl_o <= run_req_r[1] | run_act_nxt[1];
      end
   end

   // A low-nibble read captures the high nibble beside it outside chained mode; in chained mode
   // only the lowest read captures, taking the upper byte's high nibble as well so both high
   // nibbles belong to one count; the low nibbles stay live, so software must read lowest first.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hi_latch_r[0] <= 4'h0;
         hi_latch_r[1] <= 4'h0;
      end else begin
         if (rd_low_i[0]) hi_latch_r[0] <= cnt_r[0][7:4];
         if (rd_low_i[1] && !chain_16_i) hi_latch_r[1] <= cnt_r[1][7:4];
         if (rd_low_i[0] && chain_16_i) hi_latch_r[1] <= cnt_r[1][7:4];
      end
   end

   // Count readback registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan0_count_low_nibble_o  <= 4'h0;
         chan0_count_high_nibble_o <= 4'h0;
         chan1_count_low_nibble_o  <= 4'h0;
         chan1_count_high_nibble_o <= 4'h0;
      end else begin
         chan0_count_low_nibble_o  <= cnt_r[0][3:0];
         chan0_count_high_nibble_o <= hi_latch_r[0];
         chan1_count_low_nibble_o  <= cnt_r[1][3:0];
         chan1_count_high_nibble_o <= hi_latch_r[1];
      end
   end

   // Fast oscillator switch; off after reset. Software waits for it to
   // settle before starting a channel on it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_r <= `DDCT_OSC_RST;
      end else if (fast_osc_wr_i) begin
         osc_r <= fast_osc_on_i;
      end
   end
   assign fast_oscillator_on_o = osc_r;

   // Raw output toggles on the selected channel's underflow.
   wire logic timer_out_signal_evt = chain_16_i ? uflow[1] : uflow[0];

   // Port pins: special signal only with data one and float zero; data
   // zero drives low; float one releases the pin.
   wire logic timer_out_signal_gated = timer_out_signal_r & timer_out_enable_i;
   wire logic pa_lvl = port_a_cfg_i.special_sel ? (port_a_cfg_i.data & timer_out_signal_gated) : port_a_cfg_i.data;
   wire logic pb_lvl = port_b_cfg_i.special_sel ? (port_b_cfg_i.data & timer_out_signal_gated) : port_b_cfg_i.data;

   // The enable gates the output without regard to the timer clock, so a
   // toggle of the enable can cut a pulse short; that hazard is accepted.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_out_signal_r                    <= 1'b0;
         timer_out_signal_o        <= 1'b0;
         event_port_in_o           <= 1'b0;
         special_port_bit_a_o      <= `DDCT_PORT_DATA_RST;
         special_port_bit_a_oe_n_o <= `DDCT_PORT_FLOAT_RST;
         special_port_bit_b_o      <= `DDCT_PORT_DATA_RST;
         special_port_bit_b_oe_n_o <= `DDCT_PORT_FLOAT_RST;
      end else begin
         if (timer_out_signal_evt) timer_out_signal_r <= ~timer_out_signal_r;
         timer_out_signal_o        <= timer_out_signal_gated;
         event_port_in_o           <= event_clock_pin_i;
         special_port_bit_a_o      <= pa_lvl;
         special_port_bit_a_oe_n_o <= port_a_cfg_i.float_ctl;
         special_port_bit_b_o      <= pb_lvl;
         special_port_bit_b_oe_n_o <= port_b_cfg_i.float_ctl;
      end
   end

endmodule

// *** testbench/ddct_timer_sva.sv ***
/* Port checker for the dual down-counter timer.
   Assumes the timer's ports and a synchronous active-high reset. */
module ddct_timer_chk (
   input wire logic                     clk_i,              // Clock.
   input wire logic                     rst_i,              // Reset.
   input wire ddct_pkg::ddct_clk_in_t   clk_src_i,          // Source levels.
   input wire logic                     event_clock_pin_i,  // Event pin.
   input wire ddct_pkg::ddct_chan_cfg_t chan0_cfg_i,        // Channel 0 setup.
   input wire logic                     chan0_run_ctl_i,    // Run data.
   input wire logic                     chan0_run_wr_i,     // Run strobe.
   input wire logic [1:0]               rd_low_i,           // Read strobes.
   input wire logic                     timer_out_enable_i, // Output enable.
   input wire ddct_pkg::ddct_port_cfg_t port_a_cfg_i,       // Port A setup.
   input wire logic                     chan0_run_ctl_o,    // Run readback.
   input wire logic [3:0]               chan0_count_low_nibble_o,  // Low nibble.
   input wire logic [3:0]               chan0_count_high_nibble_o, // High nibble.
   input wire logic                     fast_oscillator_on_o, // Oscillator.
   input wire logic                     event_port_in_o,    // Input port copy.
   input wire logic                     timer_out_signal_o, // Timer output.
   input wire logic                     special_port_bit_a_o,      // Pin A.
   input wire logic                     special_port_bit_a_oe_n_o  // Pin A drive.
);
   timeunit 1ns;
   timeprecision 100ps;
   // Level of the source that channel 0 has selected.
   wire        src_lvl = (chan0_cfg_i.src == ddct_pkg::DDCT_SRC_EVENT) ? event_clock_pin_i :
                         (chan0_cfg_i.src == ddct_pkg::DDCT_SRC_FAST_OSC) ? clk_src_i.fast_osc_clk :
                         clk_src_i.internal_clk;
   logic [2:0] quiet_r; // Cycles the source has stayed high, saturating.
   // Seven high cycles outlast the edge pipeline, so nothing may move then.
   always_ff @(posedge clk_i) begin
      if (rst_i || !src_lvl) quiet_r <= 3'h0;
      else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A write lands in the request register first and in the readback flop one
   // edge later, so the readback is looked at two edges after the strobe.
   property p_run_take; $past(chan0_run_wr_i && chan0_run_ctl_i, 2) |-> chan0_run_ctl_o; endproperty
   a_run_take: assert property (p_run_take) else $error("run readback missed write");
   // A cleared write may drop the readback two edges later, so both are excluded.
   property p_run_hold; quiet_r == 3'h7 && $past(chan0_run_ctl_o) && !$past(chan0_run_wr_i) &&
      !$past(chan0_run_wr_i, 2) |-> chan0_run_ctl_o;
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("run readback fell without edge");
   property p_count_still; quiet_r == 3'h7 |-> $stable(chan0_count_low_nibble_o); endproperty
   a_count_still: assert property (p_count_still) else $error("count moved without edge");
   property p_hi_latch; !$past(rd_low_i[0]) && !$past(rd_low_i[0], 2) && !$past(rd_low_i[0], 3)
      |-> $stable(chan0_count_high_nibble_o); endproperty
   a_hi_latch: assert property (p_hi_latch) else $error("high nibble moved unread");
   property p_osc_reset; $past(rst_i) |-> !fast_oscillator_on_o; endproperty
   a_osc_reset: assert property (p_osc_reset) else $error("oscillator on after reset");
   property p_timer_out_signal_gate; !$past(timer_out_enable_i) |-> !timer_out_signal_o; endproperty
   a_timer_out_signal_gate: assert property (p_timer_out_signal_gate) else $error("timer output not gated");
   property p_ev_port; !$past(rst_i) |-> event_port_in_o == $past(event_clock_pin_i); endproperty
   a_ev_port: assert property (p_ev_port) else $error("event pin not seen by port");
   property p_pin_spec; !$past(rst_i) && $past(port_a_cfg_i.special_sel && !timer_out_enable_i)
      |-> !special_port_bit_a_o; endproperty
   a_pin_spec: assert property (p_pin_spec) else $error("special pin not gated");
   property p_pin_low; !$past(rst_i) && !$past(port_a_cfg_i.data) |-> !special_port_bit_a_o; endproperty
   a_pin_low: assert property (p_pin_low) else $error("pin not forced low");
   property p_pin_float; !$past(rst_i) |-> special_port_bit_a_oe_n_o == $past(port_a_cfg_i.float_ctl);
   endproperty
   a_pin_float: assert property (p_pin_float) else $error("pin drive not per float");
endmodule
bind ddct_timer ddct_timer_chk u_chk (.clk_i, .rst_i, .clk_src_i, .event_clock_pin_i, .chan0_cfg_i,
   .chan0_run_ctl_i, .chan0_run_wr_i, .rd_low_i, .timer_out_enable_i, .port_a_cfg_i, .chan0_run_ctl_o,
   .chan0_count_low_nibble_o, .chan0_count_high_nibble_o, .fast_oscillator_on_o, .event_port_in_o,
   .timer_out_signal_o, .special_port_bit_a_o, .special_port_bit_a_oe_n_o);

// *** testbench/ddct_src_model.sv ***
/* Clock sources outside the timer: prescaled clock, fast oscillator, event pin.
   Assumes the bench asks for event edges one cycle at a time. */
module ddct_src_model (
   input  wire logic             clk_i,     // Clock.
   input  wire logic             rst_i,     // Reset.
   input  wire logic             osc_on_i,  // Oscillator switch.
   input  wire logic             ev_req_i,  // Request one event edge.
   output ddct_pkg::ddct_clk_in_t clk_src_o, // Source levels.
   output logic                  ev_pin_o   // Event pin, pulled high.
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] div_r; // Prescaler.
   // The pin idles high and dips for one cycle per request.
   always_ff @(posedge clk_i) begin
      div_r <= rst_i ? 3'h0 : div_r + 3'h1;
      ev_pin_o <= rst_i | ~ev_req_i;
   end
   // A switched-off oscillator gives no edges at all; one assignment drives
   // the whole struct so that it has a single driver.
   assign clk_src_o = '{internal_clk: div_r[2], fast_osc_clk: osc_on_i & div_r[1]};
endmodule

// *** testbench/dual_down_counter_timer_tb_top.sv ***
/* Self-checking bench for the dual down-counter timer.
   Assumes the design, checker and source model are compiled first. */
module dual_down_counter_timer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
   logic clk_i = 1'b0, rst_i = 1'b1, ev_pin, ev_req = 1'b0, run = 1'b0, run_wr = 1'b0;
   logic osc = 1'b0, osc_wr = 1'b0, toe = 1'b0, run0, run1, osc_on, ev_port, timer_out_signal, pa, pa_oe, pb, pb_oe;
   logic chain = 1'b0; // Chained 16-bit mode select.
   logic [1:0] rd = 2'b00; // Low nibble read strobes.
   logic [3:0] lo0, hi0, lo1, hi1; // Counter nibbles.
   ddct_pkg::ddct_clk_in_t   clk_src; // Source levels.
   ddct_pkg::ddct_chan_cfg_t cfg = '{src: ddct_pkg::DDCT_SRC_EVENT, reload: 8'h25}; // Both channels.
   ddct_pkg::ddct_port_cfg_t pcfg = 3'b011; // Both port bits.
   int errors = 0, n_tests = 0, cyc = 0;
   // Both channels get the same setup so each is exercised.
   ddct_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .clk_src_i(clk_src), .event_clock_pin_i(ev_pin),
      .chan0_cfg_i(cfg), .chan1_cfg_i(cfg), .chain_16_i(chain), .chan0_run_ctl_i(run), .chan0_run_wr_i(run_wr),
      .chan1_run_ctl_i(run), .chan1_run_wr_i(run_wr), .fast_osc_on_i(osc), .fast_osc_wr_i(osc_wr),
      .rd_low_i(rd), .timer_out_enable_i(toe), .port_a_cfg_i(pcfg), .port_b_cfg_i(pcfg),
      .chan0_run_ctl_o(run0), .chan1_run_ctl_o(run1), .chan0_count_low_nibble_o(lo0),
      .chan0_count_high_nibble_o(hi0), .chan1_count_low_nibble_o(lo1), .chan1_count_high_nibble_o(hi1),
      .fast_oscillator_on_o(osc_on), .event_port_in_o(ev_port), .timer_out_signal_o(timer_out_signal),
      .special_port_bit_a_o(pa), .special_port_bit_a_oe_n_o(pa_oe), .special_port_bit_b_o(pb),
      .special_port_bit_b_oe_n_o(pb_oe));
   ddct_src_model u_src (.clk_i(clk_i), .rst_i(rst_i), .osc_on_i(osc_on), .ev_req_i(ev_req),
      .clk_src_o(clk_src), .ev_pin_o(ev_pin));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   // The whole run needs about 350 cycles; a hang ends it at 4000.
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 4000) begin
         errors++;
         conclude();
      end
   end
   task automatic conclude();
      if (errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Inputs always change 1 ns after an edge, clear of the sampling point.
   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr_run(input logic v);
      run = v;
      run_wr = 1'b1;
      cyc_n(1);
      run_wr = 1'b0;
      cyc_n(4);
   endtask
   // One event edge, then long enough for the edge pipeline to finish. The
   // input port copy of the pin shows the dip one edge after the pin falls.
   task automatic ev_edge();
      ev_req = 1'b1;
      cyc_n(1);
      ev_req = 1'b0;
      cyc_n(1);
      `CHK(ev_port, 1'b0)
      cyc_n(7);
   endtask
   // Start, count, stop with one last decrement, then read the halves. The
   // first counted edge finds zero, so it underflows and loads the reload value.
   task automatic t_event();
      wr_run(1'b1);
      `CHK({run0, run1, lo0}, 6'h30)
      ev_edge();
      ev_edge();
      `CHK(lo0, 4'h5)
      ev_edge();
      wr_run(1'b0);
      `CHK({run0, lo0}, 5'h14)
      ev_edge();
      `CHK({run0, run1, lo0, lo1}, 10'h033)
      ev_edge();
      `CHK({lo0, hi0}, 8'h30)
      rd = 2'b11;
      cyc_n(1);
      rd = 2'b00;
      cyc_n(3);
      `CHK({hi0, hi1}, 8'h22)
   endtask
   // The oscillator is switched on and left to settle before the timer is
   // started on it; while it is off, or while the run is clear, nothing moves.
   task automatic t_fast();
      cfg.src = ddct_pkg::DDCT_SRC_FAST_OSC;
      cyc_n(20);
      `CHK({osc_on, run0, lo0}, 6'h03)
      osc = 1'b1;
      osc_wr = 1'b1;
      cyc_n(1);
      osc_wr = 1'b0;
      cyc_n(20);
      `CHK({osc_on, run0, lo0}, 6'h23)
      wr_run(1'b1);
      cyc_n(20);
      `CHK({run0, lo0 !== 4'h3}, 2'b11)
   endtask
   // Every select, data and float setting, first with the output disabled and
   // then enabled. The single underflow of the event test left the raw output high.
   task automatic t_ports();
      logic e;
      for (int j = 0; j < 2; j++) begin
         toe = j[0];
         for (int i = 0; i < 8; i++) begin
            pcfg = i[2:0];
            cyc_n(2);
            e = i[2] ? (i[1] & toe) : i[1];
            `CHK({pa, pa_oe, pb, pb_oe, timer_out_signal}, {e, i[0], e, i[0], toe})
         end
      end
      toe = 1'b0;
   endtask
   // Chained mode after a mid-run reset: the low byte's borrow steps the high
   // byte, and a read of the lowest nibble latches both upper nibbles at once.
   task automatic t_chain();
      rst_i = 1'b1;
      cyc_n(2);
      rst_i = 1'b0;
      cyc_n(1);
      `CHK({osc_on, run0, lo0, lo1}, 10'h000)
      cfg = '{src: ddct_pkg::DDCT_SRC_EVENT, reload: 8'h10};
      chain = 1'b1;
      wr_run(1'b1);
      repeat (3) ev_edge();
      rd = 2'b01;
      cyc_n(1);
      rd = 2'b00;
      cyc_n(3);
      `CHK({hi1, lo1, hi0, lo0}, 16'h100f)
      repeat (16) ev_edge();
      rd = 2'b01;
      cyc_n(1);
      rd = 2'b00;
      cyc_n(3);
      `CHK({hi1, lo1, hi0, lo0}, 16'h0f10)
   endtask
   initial begin
      cyc_n(2);
      rst_i = 1'b0;
      cyc_n(1);
      `CHK({osc_on, pa, pa_oe}, 3'b011)
      t_event();
      t_ports();
      t_fast();
      t_chain();
      conclude();
   end
endmodule
